// *** core/tlip_ctrl.v ***
// Two-level interrupt priority, polling and vector controller with APB registers
// Summary of operation
// [RQ1] An added source with priority bit 1 outranks any source with bit 0.
// [RQ2] Added priority bits: 5 tx error, 4 dma1, 3 tx valid, 2 dma0, 1 rx error, 0 rx valid.
// [RQ3] Same level polls ext0, rx valid, timer0, rx error, dma0, ext1, tx valid, dma1, timer1, tx error, serial.
// [RQ4] Legacy priority five bits reset to zero; upper three bits read zero.
// [RQ5] Receive valid vectors 2BH; buffer not empty, or receive done under DMA.
// [RQ6] Receive error vectors 33H; CRC, overrun, abort or alignment error in either mode.
// [RQ7] Transmit valid vectors 43H; buffer not full, or transmit done under DMA.
// [RQ8] Transmit error vectors 4BH; missing ack or collision, plus underrun under DMA.
// [RQ9] High request preempts a low routine; nothing preempts its own level or higher.
`include "tlip_defines.vh"
module tlip_ctrl (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output wire [31:0] prdata,
    // Legacy sources
    input  wire        ext_irq0,
    input  wire        timer_zero_ovf,
    input  wire        ext_irq1,
    input  wire        timer_one_ovf,
    input  wire        serial_port_irq,
    // Serial link receive flags
    input  wire        rx_buffer_not_empty,
    input  wire        rx_done,
    input  wire        crc_error_flag,
    input  wire        overrun_flag,
    input  wire        receive_abort_flag,
    input  wire        alignment_error_flag,
    // Serial link transmit flags
    input  wire        tx_buffer_not_full,
    input  wire        tx_done,
    input  wire        missing_ack_flag,
    input  wire        collision_flag,
    input  wire        underrun_flag,
    // DMA completions
    input  wire        dma_ch0_done,
    input  wire        dma_ch1_done,
    // Processor core
    input  wire        core_ack,
    input  wire        core_return,
    output wire        core_irq_req,
    output wire [7:0]  core_vector,
    output wire        core_level_high,
    output wire [1:0]  in_service,
    // Summary interrupt
    output wire        irq
);
    localparam W = 4;

    // Registers
    reg  [7:0]  legacy_source_enable_reg;
    reg  [4:0]  legacy_source_priority_reg;
    reg  [5:0]  added_source_enable_reg;
    reg  [5:0]  added_source_priority_reg;
    reg  [1:0]  link_control_reg;
    reg  [2:0]  event_status_reg;
    reg  [2:0]  event_mask_reg;
    reg  [31:0] prdata_reg;
    reg  [31:0] prdata_next;
    reg         mapped_next;
    reg         mapped_reg;

    // Dispatch state
    reg         req_reg;
    reg  [7:0]  vector_reg;
    reg         level_reg;
    reg  [1:0]  isr_reg;
    reg         req_next;
    reg  [7:0]  vector_next;
    reg         level_next;
    reg  [1:0]  isr_next;
    reg  [2:0]  event_set;

    wire        setup_phase = psel & ~penable;
    wire        access_wr   = psel & penable & pwrite;
    wire        global_en   = legacy_source_enable_reg[`TLIP_BIT_GLOBAL_ENABLE];
    wire        rx_dma      = link_control_reg[`TLIP_BIT_RX_DMA_MODE];
    wire        tx_dma      = link_control_reg[`TLIP_BIT_TX_DMA_MODE];

    // Read-only snapshot of the offer and the in-service stack
    wire [12:0] dispatch_word = {isr_reg, level_reg, req_reg, 1'b0, vector_reg};

    // Derived link requests
    wire rx_valid_req = rx_dma ? rx_done : rx_buffer_not_empty;                              // RQ5
    wire rx_error_req = crc_error_flag | overrun_flag | receive_abort_flag
                      | alignment_error_flag;                                                 // RQ6
    wire tx_valid_req = tx_dma ? tx_done : tx_buffer_not_full;                               // RQ7
    wire tx_error_req = missing_ack_flag | collision_flag | (tx_dma & underrun_flag);         // RQ8

    // Sources, enables and levels in polling order
    wire [10:0] src_flag = {
        serial_port_irq,
        tx_error_req,
        timer_one_ovf,
        dma_ch1_done,
        tx_valid_req,
        ext_irq1,
        dma_ch0_done,
        rx_error_req,
        timer_zero_ovf,
        rx_valid_req,
        ext_irq0};                                                                            // RQ3
    wire [10:0] src_en = {
        legacy_source_enable_reg[`TLIP_BIT_SERIAL_PORT],
        added_source_enable_reg[`TLIP_BIT_TX_ERROR],
        legacy_source_enable_reg[`TLIP_BIT_TIMER_ONE],
        added_source_enable_reg[`TLIP_BIT_DMA_CH1],
        added_source_enable_reg[`TLIP_BIT_TX_VALID],
        legacy_source_enable_reg[`TLIP_BIT_EXT_IRQ1],
        added_source_enable_reg[`TLIP_BIT_DMA_CH0],
        added_source_enable_reg[`TLIP_BIT_RX_ERROR],
        legacy_source_enable_reg[`TLIP_BIT_TIMER_ZERO],
        added_source_enable_reg[`TLIP_BIT_RX_VALID],
        legacy_source_enable_reg[`TLIP_BIT_EXT_IRQ0]};
    wire [10:0] src_high = {
        legacy_source_priority_reg[`TLIP_BIT_SERIAL_PORT],
        added_source_priority_reg[`TLIP_BIT_TX_ERROR],
        legacy_source_priority_reg[`TLIP_BIT_TIMER_ONE],
        added_source_priority_reg[`TLIP_BIT_DMA_CH1],
        added_source_priority_reg[`TLIP_BIT_TX_VALID],
        legacy_source_priority_reg[`TLIP_BIT_EXT_IRQ1],
        added_source_priority_reg[`TLIP_BIT_DMA_CH0],
        added_source_priority_reg[`TLIP_BIT_RX_ERROR],
        legacy_source_priority_reg[`TLIP_BIT_TIMER_ZERO],
        added_source_priority_reg[`TLIP_BIT_RX_VALID],
        legacy_source_priority_reg[`TLIP_BIT_EXT_IRQ0]};                                      // RQ2

    wire [10:0] live     = src_flag & src_en & {11{global_en}};
    wire [10:0] live_hi  = live & src_high;                                                   // RQ1
    wire [10:0] live_lo  = live & ~src_high;

    wire         hit_hi;
    wire         hit_lo;
    wire [W-1:0] idx_hi;
    wire [W-1:0] idx_lo;

    // One picker per level keeps the polling order identical on both
    tlip_pick #(.N(`TLIP_NUM_SRC), .W(W)) u_pick_hi (
        .req (live_hi),
        .hit (hit_hi),
        .idx (idx_hi)
    );

    tlip_pick #(.N(`TLIP_NUM_SRC), .W(W)) u_pick_lo (
        .req (live_lo),
        .hit (hit_lo),
        .idx (idx_lo)
    );

    // Polling position to vector address
    function [7:0] vec_of;
        input [W-1:0] pos;
        begin
            case (pos)
                4'h0:    vec_of = `TLIP_VEC_EXT_IRQ0;
                4'h1:    vec_of = `TLIP_VEC_RX_VALID;      // RQ5
                4'h2:    vec_of = `TLIP_VEC_TIMER_ZERO;
                4'h3:    vec_of = `TLIP_VEC_RX_ERROR;      // RQ6
                4'h4:    vec_of = `TLIP_VEC_DMA_CH0;
                4'h5:    vec_of = `TLIP_VEC_EXT_IRQ1;
                4'h6:    vec_of = `TLIP_VEC_TX_VALID;      // RQ7
                4'h7:    vec_of = `TLIP_VEC_DMA_CH1;
                4'h8:    vec_of = `TLIP_VEC_TIMER_ONE;
                4'h9:    vec_of = `TLIP_VEC_TX_ERROR;      // RQ8
                4'hA:    vec_of = `TLIP_VEC_SERIAL_PORT;
                default: vec_of = 8'h00;
            endcase
        end
    endfunction

    // Request selection and in-service tracking
    always @* begin
        req_next    = 1'b0;
        vector_next = vector_reg;
        level_next  = level_reg;
        isr_next    = isr_reg;
        event_set   = 3'h0;
        // Accept the offered request; clear the offer so it is not taken twice
        if (core_ack && req_reg) begin
            if (level_reg) begin
                isr_next[1] = 1'b1;
                event_set[`TLIP_BIT_EV_HIGH_TAKEN] = 1'b1;
                if (isr_reg[0]) begin
                    event_set[`TLIP_BIT_EV_PREEMPT] = 1'b1;
                end
            end else begin
                isr_next[0] = 1'b1;
                event_set[`TLIP_BIT_EV_LOW_TAKEN] = 1'b1;
            end
        end else begin
            // Return ends the highest routine in service
            if (core_return) begin
                if (isr_reg[1]) begin
                    isr_next[1] = 1'b0;
                end else begin
                    isr_next[0] = 1'b0;
                end
            end
            // Using isr_next lets a return and a fresh offer share one edge
            if (hit_hi && !isr_next[1]) begin                                     // RQ9
                req_next    = 1'b1;
                vector_next = vec_of(idx_hi);
                level_next  = 1'b1;
            end else if (hit_lo && isr_next == 2'b00) begin                       // RQ9
                req_next    = 1'b1;
                vector_next = vec_of(idx_lo);
                level_next  = 1'b0;
            end
        end
    end

    // Read data, captured in the setup phase for a zero-wait answer
    always @* begin
        prdata_next = 32'h0000_0000;
        mapped_next = 1'b1;
        case (paddr)
            `TLIP_OFF_LEGACY_ENABLE:   prdata_next[7:0] = legacy_source_enable_reg;
            `TLIP_OFF_LEGACY_PRIO:     prdata_next[4:0] = legacy_source_priority_reg; // RQ4
            `TLIP_OFF_ADDED_ENABLE:    prdata_next[5:0] = added_source_enable_reg;
            `TLIP_OFF_ADDED_PRIO:      prdata_next[5:0] = added_source_priority_reg;
            `TLIP_OFF_LINK_CONTROL:    prdata_next[1:0] = link_control_reg;
            `TLIP_OFF_EVENT_STATUS:    prdata_next[2:0] = event_status_reg;
            `TLIP_OFF_EVENT_MASK:      prdata_next[2:0] = event_mask_reg;
            `TLIP_OFF_DISPATCH_STATE:  prdata_next[12:0] = dispatch_word;
            default:                   mapped_next = 1'b0;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            mapped_reg <= 1'b1;
        end else if (setup_phase) begin
            prdata_reg <= prdata_next;
            mapped_reg <= mapped_next;
        end
    end

    // Register writes; hardware set of a status bit wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            legacy_source_enable_reg   <= `TLIP_RST_LEGACY_ENABLE;
            legacy_source_priority_reg <= `TLIP_RST_LEGACY_PRIO;       // RQ4
            added_source_enable_reg    <= `TLIP_RST_ADDED_ENABLE;
            added_source_priority_reg  <= `TLIP_RST_ADDED_PRIO;
            link_control_reg           <= `TLIP_RST_LINK_CONTROL;
            event_status_reg           <= `TLIP_RST_EVENT_STATUS;
            event_mask_reg             <= `TLIP_RST_EVENT_MASK;
        end else begin
            if (access_wr && paddr == `TLIP_OFF_EVENT_STATUS) begin
                event_status_reg <= (event_status_reg & ~pwdata[2:0]) | event_set;
            end else begin
                event_status_reg <= event_status_reg | event_set;
            end
            if (access_wr) begin
                case (paddr)
                    `TLIP_OFF_LEGACY_ENABLE: legacy_source_enable_reg   <= {pwdata[7], 2'b00, pwdata[4:0]};
                    `TLIP_OFF_LEGACY_PRIO:   legacy_source_priority_reg <= pwdata[4:0];
                    `TLIP_OFF_ADDED_ENABLE:  added_source_enable_reg    <= pwdata[5:0];
                    `TLIP_OFF_ADDED_PRIO:    added_source_priority_reg  <= pwdata[5:0];  // RQ2
                    `TLIP_OFF_LINK_CONTROL:  link_control_reg           <= pwdata[1:0];
                    `TLIP_OFF_EVENT_MASK:    event_mask_reg             <= pwdata[2:0];
                    default:                 event_mask_reg             <= event_mask_reg;
                endcase
            end
        end
    end

    // Dispatch flip-flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg    <= 1'b0;
            vector_reg <= 8'h00;
            level_reg  <= 1'b0;
            isr_reg    <= 2'b00;
        end else begin
            req_reg    <= req_next;
            vector_reg <= vector_next;
            level_reg  <= level_next;
            isr_reg    <= isr_next;
        end
    end

    // Outputs
    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~mapped_reg;
    assign prdata          = prdata_reg;
    assign core_irq_req    = req_reg;
    assign core_vector     = vector_reg;
    assign core_level_high = level_reg;
    assign in_service      = isr_reg;
    assign irq             = |(event_status_reg & event_mask_reg);
endmodule // tlip_ctrl

// *** core/tlip_defines.vh ***
// Register map, field positions, reset values and vectors of the interrupt controller
`ifndef TLIP_DEFINES_VH
`define TLIP_DEFINES_VH

// Register byte offsets
`define TLIP_OFF_LEGACY_ENABLE   8'h00
`define TLIP_OFF_LEGACY_PRIO     8'h04
`define TLIP_OFF_ADDED_ENABLE    8'h08
`define TLIP_OFF_ADDED_PRIO      8'h0C
`define TLIP_OFF_LINK_CONTROL    8'h10
`define TLIP_OFF_EVENT_STATUS    8'h14
`define TLIP_OFF_EVENT_MASK      8'h18
`define TLIP_OFF_DISPATCH_STATE  8'h1C

// Reset values
`define TLIP_RST_LEGACY_ENABLE   8'h00
`define TLIP_RST_LEGACY_PRIO     5'h00
`define TLIP_RST_ADDED_ENABLE    6'h00
`define TLIP_RST_ADDED_PRIO      6'h00
`define TLIP_RST_LINK_CONTROL    2'h0
`define TLIP_RST_EVENT_STATUS    3'h0
`define TLIP_RST_EVENT_MASK      3'h0

// Legacy enable / priority fields
`define TLIP_BIT_GLOBAL_ENABLE   7
`define TLIP_BIT_EXT_IRQ0        0
`define TLIP_BIT_TIMER_ZERO      1
`define TLIP_BIT_EXT_IRQ1        2
`define TLIP_BIT_TIMER_ONE       3
`define TLIP_BIT_SERIAL_PORT     4

// Added enable / priority fields
`define TLIP_BIT_RX_VALID        0
`define TLIP_BIT_RX_ERROR        1
`define TLIP_BIT_DMA_CH0         2
`define TLIP_BIT_TX_VALID        3
`define TLIP_BIT_DMA_CH1         4
`define TLIP_BIT_TX_ERROR        5

// Link control fields
`define TLIP_BIT_RX_DMA_MODE     0
`define TLIP_BIT_TX_DMA_MODE     1

// Event status / mask fields
`define TLIP_BIT_EV_LOW_TAKEN    0
`define TLIP_BIT_EV_HIGH_TAKEN   1
`define TLIP_BIT_EV_PREEMPT      2

// Vector addresses
`define TLIP_VEC_EXT_IRQ0        8'h03
`define TLIP_VEC_TIMER_ZERO      8'h0B
`define TLIP_VEC_EXT_IRQ1        8'h13
`define TLIP_VEC_TIMER_ONE       8'h1B
`define TLIP_VEC_SERIAL_PORT     8'h23
`define TLIP_VEC_RX_VALID        8'h2B
`define TLIP_VEC_RX_ERROR        8'h33
`define TLIP_VEC_DMA_CH0         8'h3B
`define TLIP_VEC_TX_VALID        8'h43
`define TLIP_VEC_TX_ERROR        8'h4B
`define TLIP_VEC_DMA_CH1         8'h53

// Source count in polling order
`define TLIP_NUM_SRC             11

`endif

// *** core/tlip_pick.v ***
// First-set picker: lowest index wins
`include "tlip_defines.vh"
module tlip_pick #(
    parameter N = 11,
    parameter W = 4
) (
    // Requests in polling order
    input  wire [N-1:0] req,
    // Result
    output reg          hit,
    output reg  [W-1:0] idx
);
    integer i;

    always @* begin
        hit = 1'b0;
        idx = {W{1'b0}};
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (req[i]) begin
                hit = 1'b1;
                idx = i[W-1:0];
            end
        end
    end
endmodule // tlip_pick

// *** tb/tlip_ctrl_props.sv ***
// Port checker for the interrupt controller
module tlip_ctrl_props (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // APB
    input wire       psel,
    input wire       penable,
    input wire [7:0] paddr,
    input wire       pslverr,
    // Core side
    input wire       core_ack,
    input wire       core_return,
    input wire       core_irq_req,
    input wire [7:0] core_vector,
    input wire       core_level_high,
    input wire [1:0] in_service
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    unmapped_err_a: assert property (psel && !penable && paddr[7:5] != 3'h0 ##1 psel && penable |-> pslverr)
        else $error("unmapped access not flagged");
    mapped_ok_a: assert property (psel && !penable && paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0 ##1 penable |-> !pslverr)
        else $error("mapped access flagged");
    offer_drop_a: assert property (core_ack && core_irq_req |=> !core_irq_req)
        else $error("offer stands after acknowledge");
    low_enter_a: assert property (core_ack && core_irq_req && !core_level_high |=> in_service == 2'h1)
        else $error("low routine not entered");
    high_enter_a: assert property (core_ack && core_irq_req && core_level_high |=> in_service[1])
        else $error("high routine not entered");
    high_block_a: assert property (in_service[1] |-> !core_irq_req)
        else $error("offer during high routine");
    own_level_a: assert property (in_service[0] && core_irq_req |-> core_level_high)
        else $error("low offer during low routine");
    vector_set_a: assert property (core_irq_req |-> core_vector inside {8'h03, 8'h0B, 8'h13, 8'h1B, 8'h23,
        8'h2B, 8'h33, 8'h3B, 8'h43, 8'h4B, 8'h53}) else $error("illegal vector");
    return_pop_a: assert property (core_return && !core_ack && in_service == 2'h3 |=> in_service == 2'h1)
        else $error("return did not pop high level");

    cover property (in_service == 2'h3);
    cover property (core_ack && core_irq_req && core_level_high);
    cover property (pslverr);
endmodule // tlip_ctrl_props

bind tlip_ctrl tlip_ctrl_props i_tlip_ctrl_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pslverr(pslverr), .core_ack(core_ack), .core_return(core_return), .core_irq_req(core_irq_req),
    .core_vector(core_vector), .core_level_high(core_level_high), .in_service(in_service));

// *** tb/tlip_core_model.sv ***
// Processor core model: takes offered vectors, returns on command
module tlip_core_model (
    // Clock and reset
    input  logic       pclk,
    input  logic       presetn,
    // Controller side
    input  logic       core_irq_req,
    input  logic [7:0] core_vector,
    output logic       core_ack,
    output logic       core_return,
    // Bench control and log
    input  logic [3:0] ack_delay,
    input  logic       ret_cmd,
    output logic [7:0] last_vec,
    output logic [7:0] n_taken
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ack <= 1'b0;
            core_return <= 1'b0;
            wait_cnt <= 4'h0;
            last_vec <= 8'h00;
            n_taken <= 8'h00;
        end else begin
            core_return <= ret_cmd;
            // Stall lets the vector move while the offer stands
            core_ack <= core_irq_req && !core_ack && wait_cnt >= ack_delay;
            wait_cnt <= (core_irq_req && !core_ack) ? wait_cnt + 4'h1 : 4'h0;
            // An acknowledge counts only against a standing offer
            if (core_ack && core_irq_req) begin
                last_vec <= core_vector;
                n_taken <= n_taken + 8'h01;
            end
        end
    end
endmodule // tlip_core_model

// *** tb/test_tlip_ctrl.sv ***
// Testbench for the interrupt controller
module test_tlip_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ret_cmd = 1'b0, err;
    logic [7:0]  paddr = 8'h00, last_vec, n_taken, seen = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, core_ack, core_return, core_irq_req, core_level_high, irq;
    logic [7:0]  core_vector;
    logic [1:0]  in_service;
    logic [10:0] src = 11'h0;
    logic [6:0]  fl = 7'h0;
    logic [3:0]  ack_delay = 4'h0;
    int          n_mismatch = 0, samples_checked = 0, cycles = 0;
    logic [7:0]  ord_v [11] = '{8'h03, 8'h2B, 8'h0B, 8'h33, 8'h3B, 8'h13, 8'h43, 8'h53, 8'h1B, 8'h4B, 8'h23};
    logic [7:0]  cpu_v [7] = '{8'h00, 8'h33, 8'h33, 8'h33, 8'h00, 8'h4B, 8'h00};
    logic [7:0]  dma_v [7] = '{8'h2B, 8'h33, 8'h33, 8'h33, 8'h43, 8'h4B, 8'h4B};

    tlip_ctrl i_tlip_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .ext_irq0(src[0]), .rx_buffer_not_empty(src[1]), .timer_zero_ovf(src[2]), .crc_error_flag(src[3]),
        .dma_ch0_done(src[4]), .ext_irq1(src[5]), .tx_buffer_not_full(src[6]), .dma_ch1_done(src[7]),
        .timer_one_ovf(src[8]), .missing_ack_flag(src[9]), .serial_port_irq(src[10]), .rx_done(fl[0]),
        .overrun_flag(fl[1]), .receive_abort_flag(fl[2]), .alignment_error_flag(fl[3]), .tx_done(fl[4]),
        .collision_flag(fl[5]), .underrun_flag(fl[6]), .core_ack(core_ack), .core_return(core_return),
        .core_irq_req(core_irq_req), .core_vector(core_vector), .core_level_high(core_level_high),
        .in_service(in_service), .irq(irq));
    tlip_core_model i_tlip_core_model (.pclk(pclk), .presetn(presetn), .core_irq_req(core_irq_req),
        .core_vector(core_vector), .core_ack(core_ack), .core_return(core_return), .ack_delay(ack_delay),
        .ret_cmd(ret_cmd), .last_vec(last_vec), .n_taken(n_taken));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task finish_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Idle cycle first, so no request is raised twice in one step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %0h", a), e, rd);
    endtask

    // Zero vector means nothing may be taken
    task take(input logic [7:0] v);
        for (int k = 0; k < 20 && n_taken === seen; k++) @(posedge pclk);
        if (v == 8'h00) chk("taken", {24'h0, seen}, {24'h0, n_taken});
        else chk("vector", {23'h0, 1'b1, v}, {23'h0, n_taken !== seen, last_vec});
        seen = n_taken;
    endtask

    task ret;
        ret_cmd <= 1'b1;
        @(posedge pclk);
        ret_cmd <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // Sources are levels, so they are dropped before the return
    task fire(input logic [10:0] s, input logic [6:0] f, input logic [7:0] v);
        src <= s;
        fl <= f;
        take(v);
        src <= 11'h0;
        fl <= 7'h0;
        @(posedge pclk);
        if (v != 8'h00) ret();
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 32; a += 4) rdc(a[7:0], 32'h0);
        apb(1'b1, 8'h04, 32'hFFFFFFFF);
        rdc(8'h04, 32'h1F);
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdc(8'h0C, 32'h3F);
        rdc(8'h20, 32'h0);
        chk("error", 32'h1, {31'h0, err});
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h08, 32'h3F);
        apb(1'b1, 8'h00, 32'h9F);
        ack_delay <= 4'h3;
        src <= 11'h7FF;
        for (int i = 0; i < 11; i++) begin
            take(ord_v[i]);
            src[i] <= 1'b0;
            @(posedge pclk);
            ret();
        end
        ack_delay <= 4'h0;
        for (int m = 0; m < 2; m++) begin
            apb(1'b1, 8'h10, {30'h0, m[0], m[0]});
            for (int j = 0; j < 7; j++) fire(11'h0, 7'h01 << j, m ? dma_v[j] : cpu_v[j]);
        end
        fire(11'h002, 7'h0, 8'h00);
        fire(11'h040, 7'h0, 8'h00);
        fire(11'h008, 7'h0, 8'h33);
        apb(1'b1, 8'h0C, 32'h20);
        src <= 11'h201;
        take(8'h4B);
        src[9] <= 1'b0;
        take(8'h00);
        ret();
        take(8'h03);
        src <= 11'h004;
        take(8'h00);
        src <= 11'h204;
        take(8'h4B);
        src <= 11'h0;
        chk("in_service", 32'h3, {30'h0, in_service});
        rdc(8'h1C, 32'h1C4B);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, 8'h18, 32'h4);
        @(negedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        rdc(8'h14, 32'h7);
        apb(1'b1, 8'h14, 32'h4);
        @(negedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        rdc(8'h14, 32'h3);
        ret();
        ret();
        chk("in_service", 32'h0, {30'h0, in_service});
        apb(1'b1, 8'h04, 32'h10);
        src <= 11'h401;
        take(8'h23);
        src[10] <= 1'b0;
        ret();
        take(8'h03);
        src <= 11'h0;
        ret();
        finish_test();
    end
endmodule // test_tlip_ctrl
